//--- hdl/ext_pin_defs.vh
`ifndef EXT_PIN_DEFS_VH
`define EXT_PIN_DEFS_VH

// ----------------------------------------
// Timing and field constants
// ----------------------------------------
// Acknowledge time-out in clock counts
`define ACK_TIMEOUT_COUNTS 10'h3fe
// Flat bank address field in core address
`define FLAT_BANK_HI 25
`define FLAT_BANK_LO 21
// Interleaved bank address field in core address
`define ILV_BANK_HI 12
`define ILV_BANK_LO 9
// Bank address positions on general address pins
`define PIN_FLAT_HI 15
`define PIN_FLAT_LO 11
`define PIN_ILV_HI 19
`define PIN_ILV_LO 16
// Row/column field on general address pins
`define PIN_RC_HI 10
`define PIN_RC_LO 1
// Reset values
`define CS_SEL_RESET 1'b1
`define BOOT_RESET 4'h0

`endif

//--- hdl/burst_clock_gen.v
`timescale 1ns/1ps

// Divides the bus clock into a burst clock while a burst is active
module burst_clock_gen
#(
  parameter DIV = 2
)
(
  input wire clk,       // Bus clock
  input wire resetn,    // Asynchronous reset, active low
  input wire burstOn,   // Burst in progress
  output reg burstClk_r // Burst clock out
);

  reg [7:0] divCnt_r;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  // Count half periods and toggle; park low when idle
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      divCnt_r <= 8'h00;
      burstClk_r <= 1'b0;
    end
    else if (!burstOn)
    begin
      divCnt_r <= 8'h00;
      burstClk_r <= 1'b0;
    end
    else if (divCnt_r == DIV[7:0] - 8'h01)
    begin
      divCnt_r <= 8'h00;
      burstClk_r <= ~burstClk_r;
    end
    else
    begin
      divCnt_r <= divCnt_r + 8'h01;
    end
  end

endmodule

//--- hdl/ext_memory_pin_sharing.v
`timescale 1ns/1ps
`include "ext_pin_defs.vh"

// What this block does
// - Direction pin high on external reads, low on writes.
// - Other party acks cycles set for external acknowledge; error if no ack in 1022 counts.
// - Drive burst clock to synchronous memories during burst accesses.
// - Boot mode taken from four mode pins at system reset.
// - Flat SDRAM mode puts core address 25..21 on pins 15..11.
// - Interleaved SDRAM mode puts core address 12..9 on pins 19..16.
// - SDRAM cycles put row/column bits 9..0 on pins 10..1.
// - One pin shared by SDRAM select 0 and chip select 2.
// - One pin shared by SDRAM select 1 and chip select 3; SDRAM default.
module ext_memory_pin_sharing
#(
  parameter BURST_DIV = 2
)
(
  input wire clk,                       // Bus clock, 250 MHz
  input wire resetn,                    // Asynchronous reset, active low
  input wire cycReq,                    // Internal request, one-cycle pulse
  input wire cycWrite,                  // Request is a write
  input wire cycSdram,                  // Request targets SDRAM
  input wire cycBurst,                  // Request is a burst access
  input wire cycExtAck,                 // Cycle ends by external acknowledge
  input wire [3:0] cycIntLen,           // Internal wait length otherwise
  input wire [25:0] coreAddr,           // Core address
  input wire [11:0] rowColAddr,         // SDRAM row/column address
  input wire interleaveMode,            // SDRAM interleaved addressing
  input wire sel0IsGeneral,             // Shared pin 0 gives chip select 2
  input wire sel1IsGeneral,             // Shared pin 1 gives chip select 3
  input wire sel0Want,                  // SDRAM select 0 active, internal
  input wire sel1Want,                  // SDRAM select 1 active, internal
  input wire cs2Want,                   // General select 2 active, internal
  input wire cs3Want,                   // General select 3 active, internal
  input wire data_ack_in_n,             // Data acknowledge pin, active low
  input wire [3:0] bootPins,            // Startup mode pins
  output reg [24:0] addrPins_r,         // General address pins
  output reg [11:10] sdramRowColHi_r,   // Dedicated SDRAM address bits 11..10
  output reg readWrite_r,               // High read, low write
  output reg shared0_n_r,               // Pin for SDRAM select 0 or select 2
  output reg shared1_n_r,               // Pin for SDRAM select 1 or select 3
  output wire burstClk,                 // Burst clock to flash
  output reg cycDone_r,                 // Cycle ended, one-cycle pulse
  output reg cycErr_r,                  // Cycle ended in bus error, pulse
  output reg [3:0] bootMode_r           // Boot mode caught at reset release
);

  // ----------------------------------------
  // State and counters
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_END = 3'b100;
  localparam [9:0] ACK_LIMIT = `ACK_TIMEOUT_COUNTS;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [9:0] waitCnt_r;
  reg ackSync1_r;
  reg ackSync2_r;
  reg [3:0] bootSync1_r;
  reg [3:0] bootSync2_r;
  reg [1:0] bootStep_r;
  reg extAck_r;
  reg burst_r;
  reg [3:0] intLen_r;
  reg [24:0] addr_nxt;

  // Build the address pin image for a cycle
  function [24:0] pinImage;
    input sd;
    input ilv;
    input [25:0] ca;
    input [11:0] rc;
    reg [24:0] img;
    begin
      img = ca[24:0];
      if (sd)
      begin
        img[`PIN_RC_HI:`PIN_RC_LO] = rc[9:0];
        if (ilv)
          img[`PIN_ILV_HI:`PIN_ILV_LO] = ca[`ILV_BANK_HI:`ILV_BANK_LO];
        else
          img[`PIN_FLAT_HI:`PIN_FLAT_LO] = ca[`FLAT_BANK_HI:`FLAT_BANK_LO];
      end
      pinImage = img;
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops on acknowledge and boot pins
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ackSync1_r <= 1'b1;
      ackSync2_r <= 1'b1;
      bootSync1_r <= `BOOT_RESET;
      bootSync2_r <= `BOOT_RESET;
    end
    else
    begin
      ackSync1_r <= data_ack_in_n;
      ackSync2_r <= ackSync1_r;
      bootSync1_r <= bootPins;
      bootSync2_r <= bootSync1_r;
    end
  end

  // Boot mode caught once at the third edge, when the second stage holds the pins
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bootStep_r <= 2'h0;
      bootMode_r <= `BOOT_RESET;
    end
    else if (bootStep_r != 2'h3)
    begin
      bootStep_r <= bootStep_r + 2'h1;
      if (bootStep_r == 2'h2)
        bootMode_r <= bootSync2_r;
    end
  end

  // ----------------------------------------
  // Cycle state machine
  // ----------------------------------------
  always @*
  begin
    addr_nxt = pinImage(cycSdram, interleaveMode, coreAddr, rowColAddr);
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (cycReq)
          state_nxt = ST_WAIT;
      ST_WAIT:
        if (extAck_r && !ackSync2_r)
          state_nxt = ST_END;
        else if (extAck_r && waitCnt_r == ACK_LIMIT - 10'd1)
          state_nxt = ST_END;
        else if (!extAck_r && waitCnt_r[3:0] == intLen_r)
          state_nxt = ST_END;
      ST_END:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Registers of the cycle, its counter and its answer
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      waitCnt_r <= 10'h000;
      extAck_r <= 1'b0;
      burst_r <= 1'b0;
      intLen_r <= 4'h0;
      addrPins_r <= 25'h000_0000;
      sdramRowColHi_r <= 2'h0;
      readWrite_r <= 1'b1;
      cycDone_r <= 1'b0;
      cycErr_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cycDone_r <= 1'b0;
      cycErr_r <= 1'b0;
      if (state_r == ST_IDLE && cycReq)
      begin
        waitCnt_r <= 10'h000;
        extAck_r <= cycExtAck;
        burst_r <= cycBurst;
        intLen_r <= cycIntLen;
        addrPins_r <= addr_nxt;
        sdramRowColHi_r <= rowColAddr[11:10];
        readWrite_r <= ~cycWrite;
      end
      else if (state_r == ST_WAIT)
      begin
        waitCnt_r <= waitCnt_r + 10'd1;
        if (state_nxt == ST_END)
        begin
          cycDone_r <= 1'b1;
          cycErr_r <= extAck_r && ackSync2_r;
          waitCnt_r <= 10'h000;
          burst_r <= 1'b0;
        end
      end
      else if (state_r == ST_END)
      begin
        readWrite_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Shared chip-select pins
  // ----------------------------------------
  // Pin function chosen by the select inputs; active low
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shared0_n_r <= 1'b1;
      shared1_n_r <= 1'b1;
    end
    else
    begin
      shared0_n_r <= sel0IsGeneral ? ~cs2Want : ~sel0Want;
      shared1_n_r <= sel1IsGeneral ? ~cs3Want : ~sel1Want;
    end
  end

  // ----------------------------------------
  // Burst clock
  // ----------------------------------------
  burst_clock_gen #(.DIV(BURST_DIV)) burstGen
  (
    .clk(clk),
    .resetn(resetn),
    .burstOn(burst_r && state_r == ST_WAIT),
    .burstClk_r(burstClk)
  );

endmodule

//--- sim/ext_mem_props_properties.sv
`timescale 1ns/1ps
// Checks direction, time-out, address mapping and shared selects
module ext_mem_props(
  input wire clk, // Clock
  input wire resetn, // Reset
  input wire cycReq, // Request
  input wire cycWrite, // Write
  input wire cycSdram, // SDRAM
  input wire interleaveMode, // Bank mode
  input wire [25:0] coreAddr, // Address
  input wire [11:0] rowColAddr, // Row/col
  input wire sel0IsGeneral, // Pin 0 use
  input wire sel1IsGeneral, // Pin 1 use
  input wire sel0Want, // Select 0
  input wire sel1Want, // Select 1
  input wire cs2Want, // Select 2
  input wire cs3Want, // Select 3
  input wire [24:0] addrPins_r, // Pins
  input wire [11:10] sdramRowColHi_r, // High bits
  input wire readWrite_r, // Direction
  input wire shared0_n_r, // Pin 0
  input wire shared1_n_r, // Pin 1
  input wire cycDone_r, // Done
  input wire cycErr_r // Error
);
  reg busy_r;
  reg [10:0] cnt_r;
  reg [25:0] caPast_r;
  reg [11:0] rcPast_r;
  wire takeNow = cycReq && !busy_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Tracks the open cycle and counts edges since it was taken
  always @(posedge clk or negedge resetn)
    if (!resetn)
      {busy_r, cnt_r} <= 12'h000;
    else if (cycDone_r)
      busy_r <= 1'b0;
    else if (takeNow)
      {busy_r, cnt_r} <= 12'h800;
    else
      cnt_r <= cnt_r + 11'h001;
  // Keeps the request fields one cycle back
  always @(posedge clk)
    {caPast_r, rcPast_r} <= {coreAddr, rowColAddr};
  chk_rw_level:
  assert property (takeNow |=> readWrite_r == !$past(cycWrite)) else $error("bad direction");
  chk_rw_back:
  assert property (cycDone_r |=> readWrite_r) else $error("direction not back to read");
  chk_err_count:
  assert property (cycErr_r |-> cnt_r == 11'h3fe) else $error("time-out at wrong count");
  chk_err_done:
  assert property (cycErr_r |-> cycDone_r ##1 !cycErr_r) else $error("error without end");
  chk_flat_bank:
  assert property (takeNow && cycSdram && !interleaveMode |=> addrPins_r[15:11] ==
    caPast_r[25:21] && addrPins_r[10:1] == rcPast_r[9:0]) else $error("flat map wrong");
  chk_ilv_bank:
  assert property (takeNow && cycSdram && interleaveMode |=> addrPins_r[19:16] ==
    caPast_r[12:9] && sdramRowColHi_r == rcPast_r[11:10]) else $error("ilv map wrong");
  chk_pin0_fn:
  assert property (resetn |=> shared0_n_r == ($past(sel0IsGeneral) ? !$past(cs2Want)
    : !$past(sel0Want))) else $error("shared pin 0 wrong");
  chk_pin1_fn:
  assert property (resetn |=> shared1_n_r == ($past(sel1IsGeneral) ? !$past(cs3Want)
    : !$past(sel1Want))) else $error("shared pin 1 wrong");
endmodule
bind ext_memory_pin_sharing ext_mem_props i_chk(.clk(clk), .resetn(resetn), .cycReq(cycReq),
  .cycWrite(cycWrite), .cycSdram(cycSdram), .interleaveMode(interleaveMode),
  .coreAddr(coreAddr), .rowColAddr(rowColAddr), .sel0IsGeneral(sel0IsGeneral),
  .sel1IsGeneral(sel1IsGeneral), .sel0Want(sel0Want), .sel1Want(sel1Want),
  .cs2Want(cs2Want), .cs3Want(cs3Want), .addrPins_r(addrPins_r),
  .sdramRowColHi_r(sdramRowColHi_r), .readWrite_r(readWrite_r), .shared0_n_r(shared0_n_r),
  .shared1_n_r(shared1_n_r), .cycDone_r(cycDone_r), .cycErr_r(cycErr_r));

//--- sim/ext_mem_partner.sv
`timescale 1ns/1ps
// Memory side: acks after lat edges, never when lat is zero
module ext_mem_partner(
  input wire clk, // Clock
  input wire start, // Cycle opened
  input wire done, // Cycle closed
  input wire [11:0] lat, // Delay
  output reg ackN // Ack pin
);
  initial ackN = 1'b1;
  // Ack stays low until the cycle ends, then is driven high again
  always
  begin
    @(posedge clk);
    if (start && lat != 12'h000)
    begin
      repeat (lat) @(posedge clk);
      ackN <= 1'b0;
      while (!done) @(posedge clk);
      ackN <= 1'b1;
    end
  end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
// Bench for the shared memory pin block
module tb_top;
  reg clk = 1'b0, resetn = 1'b0, cycReq = 1'b0, cycWrite = 1'b0, cycSdram = 1'b0;
  reg cycBurst = 1'b0, cycExtAck = 1'b0, interleaveMode = 1'b0, sel0IsGeneral = 1'b0;
  reg sel1IsGeneral = 1'b0, sel0Want = 1'b0, sel1Want = 1'b1, cs2Want = 1'b0, cs3Want = 1'b0;
  reg [3:0] cycIntLen = 4'h0, bootPins = 4'ha;
  reg [11:0] rowColAddr = 12'h000, lat = 12'h000;
  reg [25:0] coreAddr = 26'h000_0000;
  wire data_ack_in_n, readWrite_r, shared0_n_r, shared1_n_r, burstClk, cycDone_r, cycErr_r;
  wire [24:0] addrPins_r;
  wire [11:10] sdramRowColHi_r;
  wire [3:0] bootMode_r;
  integer errors = 0, tests_run = 0;
  // Clock and parts
  initial forever #2 clk = ~clk;
  ext_memory_pin_sharing i_dut(.*);
  ext_mem_partner i_mem(.clk(clk), .start(cycReq && cycExtAck), .done(cycDone_r),
    .lat(lat), .ackN(data_ack_in_n));
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Reset with mode pins held, then read back the mode
  task boot(input [3:0] b);
    @(posedge clk);
    bootPins <= b;
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("bootMode", bootMode_r, b);
    chk("shared1", shared1_n_r, !sel1Want);
  endtask
  // One external cycle with its pins, length and error judged
  task run(input w, sd, bu, il, ea, input [3:0] len, input [11:0] lt,
    input [25:0] ca, input [11:0] rc);
    reg [24:0] e;
    reg p;
    integer n, r;
    e = ca[24:0];
    if (sd) e[10:1] = rc[9:0];
    if (sd && il) e[19:16] = ca[12:9];
    if (sd && !il) e[15:11] = ca[25:21];
    n = 0;
    r = 0;
    p = 1'b0;
    @(posedge clk);
    {cycReq, cycWrite, cycSdram, cycBurst, interleaveMode} <= {1'b1, w, sd, bu, il};
    {cycExtAck, cycIntLen, lat, coreAddr, rowColAddr} <= {ea, len, lt, ca, rc};
    @(posedge clk);
    cycReq <= 1'b0;
    while (!cycDone_r && n < 1100)
    begin
      @(posedge clk);
      #1 n++;
      r += burstClk && !p;
      p = burstClk;
      if (n == 1)
      begin
        chk("dir", readWrite_r, !w);
        chk("addr", addrPins_r, e);
        if (sd) chk("rcHi", sdramRowColHi_r, rc[11:10]);
      end
    end
    chk("done", cycDone_r, 1);
    chk("err", cycErr_r, ea && lt == 0);
    if (!ea) chk("len", n, len + 1);
    if (ea && lt == 0) chk("tmo", n, 1022);
    if (ea && lt != 0) chk("ackLen", n >= lt + 3 && n <= lt + 5, 1);
    chk("burst", r != 0, bu);
    @(posedge clk);
    #1 chk("dirIdle", readWrite_r, 1);
  endtask
  // Every mix of pin function and select requests
  task sel;
    integer i;
    for (i = 0; i < 64; i++)
    begin
      @(posedge clk);
      {sel0IsGeneral, sel1IsGeneral, sel0Want, sel1Want, cs2Want, cs3Want} <= i[5:0];
      @(posedge clk);
      #1 chk("pin0", shared0_n_r, !(i[5] ? i[1] : i[3]));
      chk("pin1", shared1_n_r, !(i[4] ? i[0] : i[2]));
    end
  endtask
  // Main sequence
  initial
  begin
    boot(4'ha);
    run(0, 0, 0, 0, 0, 4'h3, 12'h000, 26'h2ab_cdef, 12'h000);
    run(1, 1, 0, 0, 1, 4'h0, 12'h005, 26'h3e0_1234, 12'hc35);
    run(0, 1, 0, 1, 1, 4'h0, 12'h014, 26'h15a_5a00, 12'h3ff);
    run(0, 0, 1, 0, 1, 4'h0, 12'h01e, 26'h000_0001, 12'h000);
    run(1, 0, 0, 0, 1, 4'h0, 12'h000, 26'h1ff_ffff, 12'h000);
    run(1, 0, 0, 0, 0, 4'hf, 12'h000, 26'h000_0000, 12'h000);
    boot(4'h5);
    sel;
    finish_test;
  end
  // Watchdog
  initial
  begin
    #50000;
    errors++;
    finish_test;
  end
endmodule
